//--- verilog/adcci_cfg.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ADCCI_CFG_SVH
`define ADCCI_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define ADCCI_CSR_IDX 6'h36
`define ADCCI_HIGH_IDX 6'h37
`define ADCCI_LOW_IDX 6'h38
`define ADCCI_STAT_IDX 6'h39
`define ADCCI_MASK_IDX 6'h3a

// Field positions.
`define ADCCI_CSR_EOC 7
`define ADCCI_CSR_SPEED 6
`define ADCCI_CSR_ON 5
`define ADCCI_LOW_SLOW 3
`define ADCCI_ST_DONE 0
`define ADCCI_ST_OVR 1

// Reset values.
`define ADCCI_CSR_RST 8'h00
`define ADCCI_LOW_RST 8'h00
`define ADCCI_RES_RST 10'h000

// Converter clock divider terminal counts (divide by count plus one).
`define ADCCI_DIV1_LIM 2'h0
`define ADCCI_DIV2_LIM 2'h1
`define ADCCI_DIV4_LIM 2'h3

// Converter timing.
`define ADCCI_SAMPLE_TICKS 2'h2
`define ADCCI_PCLK_NS 20
`define ADCCI_WAKE_SETTLE_NS 1000
`define ADCCI_WAKE_CYC ((`ADCCI_WAKE_SETTLE_NS + `ADCCI_PCLK_NS - 1) / `ADCCI_PCLK_NS)

`endif

//--- verilog/adcci_pkg.sv
// Types shared by the converter control block modules.
package adcci_pkg;

  // Converter power mode; codes are Gray along off, run, halt.
  typedef enum logic [1:0] {
    ADCCI_OFF = 2'b00,
    ADCCI_RUN = 2'b01,
    ADCCI_HALT = 2'b11,
    ADCCI_SETTLE = 2'b10
  } adcci_mode_t;

  // Successive approximation sequence states.
  typedef enum logic [1:0] {
    ADCCI_IDLE = 2'b00,
    ADCCI_SAMPLE = 2'b01,
    ADCCI_CONV = 2'b11,
    ADCCI_DONE = 2'b10
  } adcci_sar_st_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } adcci_div_t;

  typedef struct packed {
    adcci_sar_st_t st;
    logic [1:0] scnt;
    logic [3:0] bitn;
    logic [9:0] trial;
    logic sample;
    logic done;
    logic [9:0] result;
  } adcci_sar_t;

  typedef struct packed {
    logic [3:0] ch;
    logic speed;
    logic on;
    logic eoc;
    logic slow;
    logic [9:0] result;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    adcci_mode_t mode;
    logic [7:0] settle;
    logic pwr;
    logic [9:0] pin;
  } adcci_top_t;

endpackage : adcci_pkg

//--- verilog/adcci_clkdiv.sv
// Converter clock enable generator dividing the APB clock by one, two or four.
`timescale 1ns/1ps
`default_nettype none
`include "adcci_cfg.svh"

module adcci_clkdiv import adcci_pkg::*; (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic run, // Converter running.
  input wire logic slow, // Divide by four.
  input wire logic speed, // Undivided when slow is low.
  output logic tick // One-cycle converter clock enable.
);

  adcci_div_t r;
  adcci_div_t n;
  logic [1:0] lim;

  // Counting from zero while stopped keeps the first tick a full period away.
  always_comb begin
    lim = slow ? `ADCCI_DIV4_LIM : (speed ? `ADCCI_DIV1_LIM : `ADCCI_DIV2_LIM);
    n = r;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 2'h0;
    end else if (r.cnt >= lim) begin
      n.cnt = 2'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 2'h1;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  div_four_a: assert property (tick && slow ##1 slow |-> !tick)
    else $error("Converter enable too fast in divide-by-four mode.");
  div_two_a: assert property (tick && !slow && !speed ##1 !slow && !speed |-> !tick)
    else $error("Converter enable too fast in divide-by-two mode.");

endmodule : adcci_clkdiv
`default_nettype wire

//--- verilog/adcci_sar.sv
// Successive approximation sequencer driving the analog core's trial code.
`timescale 1ns/1ps
`default_nettype none
`include "adcci_cfg.svh"

module adcci_sar import adcci_pkg::*; (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic run, // Convert continuously while high.
  input wire logic abort, // Drop the current conversion.
  input wire logic tick, // Converter clock enable.
  input wire logic comp, // Comparator: input at or above trial.
  output logic sample, // Sample switch closed.
  output logic [9:0] trial, // Trial code to the DAC.
  output logic done, // One-cycle pulse with a new result.
  output logic [9:0] result // Last result.
);

  adcci_sar_t r;
  adcci_sar_t n;

  // The comparator is read one converter tick after its trial code was set.
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (abort || !run) begin
      n.st = ADCCI_IDLE;
      n.sample = 1'b0;
      n.trial = 10'h000;
    end else if (tick) begin
      unique case (r.st)
        ADCCI_IDLE, ADCCI_DONE: begin
          if (r.st == ADCCI_DONE) begin
            n.result = r.trial;
            n.done = 1'b1;
          end
          n.st = ADCCI_SAMPLE;
          n.sample = 1'b1;
          n.scnt = 2'h0;
        end
        ADCCI_SAMPLE: begin
          if (r.scnt == `ADCCI_SAMPLE_TICKS - 2'h1) begin
            n.st = ADCCI_CONV;
            n.sample = 1'b0;
            n.bitn = 4'h9;
            n.trial = 10'h200;
          end else begin
            n.scnt = r.scnt + 2'h1;
          end
        end
        ADCCI_CONV: begin
          if (!comp) begin
            n.trial[r.bitn] = 1'b0;
          end
          if (r.bitn == 4'h0) begin
            n.st = ADCCI_DONE;
          end else begin
            n.trial[r.bitn - 4'h1] = 1'b1;
            n.bitn = r.bitn - 4'h1;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sample = r.sample;
  assign trial = r.trial;
  assign done = r.done;
  assign result = r.result;

endmodule : adcci_sar
`default_nettype wire

//--- verilog/adcci_top.sv
// Control and result interface of the 10-bit converter with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "adcci_cfg.svh"

module adcci_top import adcci_pkg::*; (
  input wire logic pclk, // APB clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq, // Level interrupt.
  input wire logic halt_req, // Chip in halt mode.
  input wire logic [9:0] ain_level, // Digital level of the analog pins.
  output logic [9:0] port_level, // Pin levels for the port read path.
  output logic adc_power_on, // Analog core powered.
  output logic [3:0] adc_channel, // Input multiplexer select.
  output logic adc_sample, // Sample switch closed.
  output logic [9:0] adc_trial, // Trial code to the DAC.
  input wire logic adc_comp // Comparator result.
);

  localparam logic [7:0] CSR_A = {`ADCCI_CSR_IDX, 2'b00};
  localparam logic [7:0] HIGH_A = {`ADCCI_HIGH_IDX, 2'b00};
  localparam logic [7:0] LOW_A = {`ADCCI_LOW_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {`ADCCI_STAT_IDX, 2'b00};
  localparam logic [7:0] MASK_A = {`ADCCI_MASK_IDX, 2'b00};
  localparam logic [7:0] WAKE_CYC = 8'(`ADCCI_WAKE_CYC);

  adcci_top_t r;
  adcci_top_t n;
  logic setup;
  logic acc;
  logic wr_csr;
  logic wr_low;
  logic wr_stat;
  logic wr_mask;
  logic rd_high;
  logic abort;
  logic tick;
  logic sar_done;
  logic [9:0] sar_result;
  logic eoc_set;
  logic eoc_clr;
  logic [1:0] events;
  logic run;

  // APB phase decode; a write lands only at the edge where pready is sampled high.
  assign setup = psel & ~penable;
  assign acc = psel & penable & r.pready;
  assign wr_csr = acc & pwrite & (paddr == CSR_A);
  assign wr_low = acc & pwrite & (paddr == LOW_A);
  assign wr_stat = acc & pwrite & (paddr == STAT_A);
  assign wr_mask = acc & pwrite & (paddr == MASK_A);
  assign rd_high = acc & ~pwrite & (paddr == HIGH_A);
  assign run = (r.mode == ADCCI_RUN);

  // A new channel while running throws the conversion away at once.
  assign abort = wr_csr & run & (pwdata[3:0] != r.ch);

  // A result from an aborted conversion belongs to the old channel and is dropped.
  assign eoc_set = sar_done & ~abort;
  assign eoc_clr = wr_csr | rd_high;
  assign events = {eoc_set & r.eoc, eoc_set};

  adcci_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .slow(r.slow),
    .speed(r.speed),
    .tick(tick)
  );

  adcci_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .abort(abort),
    .tick(tick),
    .comp(adc_comp),
    .sample(adc_sample),
    .trial(adc_trial),
    .done(sar_done),
    .result(sar_result)
  );

  // Next-state logic for registers, APB answer, power mode and interrupt.
  always_comb begin
    n = r;
    n.pready = setup;
    n.pslverr = 1'b0;
    n.pin = ain_level;

    // Read data is latched in the setup cycle and presented in the access cycle.
    if (setup) begin
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        CSR_A: n.prdata[7:0] = {r.eoc, r.speed, r.on, 1'b0, r.ch};
        HIGH_A: n.prdata[7:0] = r.result[9:2];
        LOW_A: n.prdata[7:0] = {4'h0, r.slow, 1'b0, r.result[1:0]};
        STAT_A: n.prdata[1:0] = r.status;
        MASK_A: n.prdata[1:0] = r.mask;
        default: n.pslverr = ~pwrite;
      endcase
      if (pwrite && !(paddr inside {CSR_A, HIGH_A, LOW_A, STAT_A, MASK_A})) begin
        n.pslverr = 1'b1;
      end
    end

    // Control and status: channel, speed and converter on are software owned.
    if (wr_csr) begin
      n.ch = pwdata[3:0];
      n.speed = pwdata[`ADCCI_CSR_SPEED];
      n.on = pwdata[`ADCCI_CSR_ON];
    end
    if (wr_low) begin
      n.slow = pwdata[`ADCCI_LOW_SLOW];
    end
    if (wr_mask) begin
      n.mask = pwdata[1:0];
    end

    // The flag set by a finishing conversion wins over a clear in the same cycle.
    if (eoc_set) begin
      n.eoc = 1'b1;
      n.result = sar_result;
    end else if (eoc_clr) begin
      n.eoc = 1'b0;
    end

    // Sticky event bits, cleared by writing one; a new event wins.
    n.status = (r.status & ~({2{wr_stat}} & pwdata[1:0])) | events;

    // Power mode; wait mode has no input here because it changes nothing.
    unique case (r.mode)
      ADCCI_OFF: begin
        if (halt_req) begin
          n.mode = ADCCI_HALT;
        end else if (r.on) begin
          n.mode = ADCCI_RUN;
        end
      end
      ADCCI_RUN: begin
        if (halt_req) begin
          n.mode = ADCCI_HALT;
        end else if (!r.on) begin
          n.mode = ADCCI_OFF;
        end
      end
      ADCCI_HALT: begin
        if (!halt_req) begin
          n.mode = ADCCI_SETTLE;
          n.settle = WAKE_CYC;
        end
      end
      ADCCI_SETTLE: begin
        if (halt_req) begin
          n.mode = ADCCI_HALT;
        end else if (r.settle <= 8'h01) begin
          n.mode = r.on ? ADCCI_RUN : ADCCI_OFF;
        end else begin
          n.settle = r.settle - 8'h01;
        end
      end
    endcase

    // The core is kept powered while settling so its bias is ready at the end.
    n.pwr = (n.mode == ADCCI_RUN) || (n.mode == ADCCI_SETTLE);

    // Masks reset to zero, so the converter alone never interrupts.
    n.irq = |(n.status & n.mask);
  end

  // State register; result bytes have no defined reset content and clear to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign port_level = r.pin;
  assign adc_power_on = r.pwr;
  assign adc_channel = r.ch;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pin_follow_a: assert property (##1 port_level == $past(ain_level))
    else $error("Port level does not follow the pin.");

  chan_write_a: assert property (wr_csr |=> adc_channel == $past(pwdata[3:0]))
    else $error("Channel select not taken from control write.");

  start_run_a: assert property (r.mode == ADCCI_OFF && r.on && !halt_req |=> adc_power_on)
    else $error("Converter did not start with converter on set.");

  eoc_set_a: assert property (sar_done && !abort |=> r.eoc && r.result == $past(sar_result))
    else $error("Finished conversion did not raise the flag with its result.");

  eoc_clear_a: assert property ((wr_csr || rd_high) && !sar_done |=> !r.eoc)
    else $error("Flag not cleared by control write or high read.");

  chg_abort_a: assert property (abort |=> !adc_sample && adc_trial == 10'h000 && !r.eoc)
    else $error("Channel change did not abort the conversion.");

  off_stop_a: assert property (wr_csr && !pwdata[`ADCCI_CSR_ON] && run && !halt_req
                               ##1 !halt_req |=> !adc_power_on)
    else $error("Converter kept running after converter on cleared.");

  // The sequencer sees the mode one edge late, so the sample switch opens a cycle after power.
  halt_off_a: assert property (halt_req |=> !adc_power_on ##1 !adc_sample)
    else $error("Converter active in halt mode.");

  settle_wait_a: assert property ($fell(halt_req) |-> !run [*8])
    else $error("Conversions resumed before the settle time.");

  high_read_a: assert property (setup && !pwrite && paddr == HIGH_A
                                |=> pready && prdata[7:0] == $past(r.result[9:2]))
    else $error("High byte does not show result bits 9:2.");

  low_read_a: assert property (setup && !pwrite && paddr == LOW_A |=> prdata[7:4] == 4'h0
                               && !prdata[2] && prdata[1:0] == $past(r.result[1:0]))
    else $error("Low byte layout wrong.");

  no_irq_a: assert property (r.mask == 2'h0 |-> !irq)
    else $error("Interrupt raised with all events masked.");

  csr_zero_a: assert property (setup && !pwrite && paddr == CSR_A |=> !prdata[4])
    else $error("Control bit 4 does not read zero.");

  conv_done_c: cover property (sar_done ##[1:20] rd_high);
  chan_abort_c: cover property (run && adc_sample ##1 abort);
  halt_wake_c: cover property (run ##1 halt_req ##1 !halt_req ##[1:100] run);
  overrun_c: cover property (eoc_set && r.eoc);

endmodule : adcci_top
`default_nettype wire

//--- tb/adcci_core_model.sv
// Behavioural analog core: a fixed level per channel and a comparator.
`timescale 1ns/1ps
`default_nettype none

module adcci_core_model (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic adc_power_on, // Core powered.
  input wire logic [3:0] adc_channel, // Multiplexer select.
  input wire logic adc_sample, // Sample switch closed.
  input wire logic [9:0] adc_trial, // Trial code.
  output logic adc_comp // Comparator output.
);
  logic [9:0] held;
  logic wob;

  // The held level follows the selected channel while sampling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 10'h000;
      wob <= 1'b0;
    end else begin
      wob <= ~wob;
      if (adc_sample && adc_power_on) begin
        held <= {adc_channel, 2'b10, adc_channel};
      end
    end
  end

  // Unpowered, the comparator output is garbage, so it toggles every cycle.
  assign adc_comp = adc_power_on ? (held >= adc_trial) : wob;
endmodule : adcci_core_model
`default_nettype wire

//--- tb/adcci_top_test.sv
// Self-checking bench for the converter control block over APB.
`timescale 1ns/1ps
`default_nettype none
`include "adcci_cfg.svh"

module adcci_top_test;
  localparam logic [7:0] A_CSR = {`ADCCI_CSR_IDX, 2'b00};
  localparam logic [7:0] A_HIGH = {`ADCCI_HIGH_IDX, 2'b00};
  localparam logic [7:0] A_LOW = {`ADCCI_LOW_IDX, 2'b00};
  localparam logic [7:0] A_STAT = {`ADCCI_STAT_IDX, 2'b00};
  localparam logic [7:0] A_MASK = {`ADCCI_MASK_IDX, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, halt_req;
  logic adc_power_on, adc_sample, adc_comp, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, lo;
  logic [9:0] ain_level, port_level, adc_trial;
  logic [3:0] adc_channel, ch;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;

  adcci_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .halt_req(halt_req), .ain_level(ain_level),
    .port_level(port_level), .adc_power_on(adc_power_on), .adc_channel(adc_channel),
    .adc_sample(adc_sample), .adc_trial(adc_trial), .adc_comp(adc_comp));

  adcci_core_model core (.pclk(pclk), .presetn(presetn), .adc_power_on(adc_power_on),
    .adc_channel(adc_channel), .adc_sample(adc_sample), .adc_trial(adc_trial),
    .adc_comp(adc_comp));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // A hang anywhere ends the run as a mismatch.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  function automatic logic [9:0] lvl(input logic [3:0] c);
    return {c, 2'b10, c};
  endfunction : lvl

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts edges up to the next rising edge of the sample switch.
  task automatic rise(output int k);
    k = 0;
    do begin @(posedge pclk); k++; end while (adc_sample !== 1'b0);
    do begin @(posedge pclk); k++; end while (adc_sample !== 1'b1);
  endtask : rise

  task automatic poll;
    do apb(1'b0, A_CSR, 32'h0); while (rd[7] !== 1'b1);
  endtask : poll

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    halt_req = 1'b0;
    ain_level = 10'h000; // Pins act as plain inputs with no pull or interrupt.
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, refusals and fixed bits.
    apb(1'b0, A_CSR, 32'h0);
    chk("csr reset", rd, 32'h0);
    apb(1'b0, 8'hf0, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, A_CSR, 32'h9f);
    apb(1'b0, A_CSR, 32'h0);
    chk("csr fixed bits", rd, 32'h0f);
    apb(1'b1, A_HIGH, 32'hff);
    chk("high write err", er, 1'b0);
    apb(1'b1, A_LOW, 32'hff);
    apb(1'b0, A_LOW, 32'h0);
    chk("low fixed bits", rd & 32'hfc, 32'h08);
    // Each divider setting: period and result bytes; flag clearing in divide-by-four only.
    for (int i = 0; i < 4; i++) begin
      ch = 4'(i * 5);
      apb(1'b1, A_LOW, {28'h0, i < 2, 3'b000});
      apb(1'b1, A_CSR, {24'h0, 1'b0, i[0], 2'b10, ch});
      repeat (2) @(posedge pclk);
      chk("mux select", adc_channel, ch);
      chk("power on", adc_power_on, 1'b1);
      rise(n);
      rise(n);
      chk("period", n, 13 * (i < 2 ? 4 : (i == 2 ? 2 : 1)));
      poll();
      apb(1'b0, A_LOW, 32'h0);
      lo = rd;
      apb(1'b0, A_HIGH, 32'h0);
      chk("result", {rd[7:0], lo[1:0]}, lvl(ch));
      if (i < 2) begin
        apb(1'b0, A_CSR, 32'h0);
        chk("flag cleared", rd[7], 1'b0);
      end
    end
    // A channel change mid-conversion restarts on the new channel.
    apb(1'b1, A_LOW, 32'h08);
    apb(1'b1, A_CSR, 32'h23);
    rise(n);
    repeat (20) @(posedge pclk);
    apb(1'b1, A_CSR, 32'h29);
    apb(1'b0, A_CSR, 32'h0);
    chk("abort flag", rd[7], 1'b0);
    poll();
    apb(1'b0, A_HIGH, 32'h0);
    chk("new channel", rd, 32'(lvl(4'h9) >> 2));
    ain_level <= 10'h2b6;
    repeat (3) @(posedge pclk);
    chk("port read", port_level, 10'h2b6);
    // Stop, then raise, mask and clear the completion interrupt.
    poll();
    apb(1'b1, A_CSR, 32'h09);
    repeat (4) @(posedge pclk);
    chk("power off", adc_power_on, 1'b0);
    apb(1'b0, A_STAT, 32'h0);
    chk("done status", rd[0], 1'b1);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, A_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, A_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    apb(1'b0, A_STAT, 32'h0);
    chk("status clear", rd, 32'h0);
    apb(1'b1, A_MASK, 32'h0);
    repeat (100) @(posedge pclk);
    apb(1'b0, A_CSR, 32'h0);
    chk("stopped", rd, 32'h09);
    // Halt powers the core down; conversions wait out the settle time.
    apb(1'b1, A_CSR, 32'h29);
    rise(n);
    halt_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("halt power", adc_power_on, 1'b0);
    halt_req <= 1'b0;
    rise(n);
    chk("settle wait", 32'(n >= `ADCCI_WAKE_CYC), 32'h1);
    poll();
    apb(1'b0, A_HIGH, 32'h0);
    chk("after halt", rd, 32'(lvl(4'h9) >> 2));
    report_and_stop();
  end
endmodule : adcci_top_test
`default_nettype wire
